// [design/bus_cond_pkg.sv]
package bus_cond_pkg;

    // ------------------------------------------------------------
    // Clock and time base
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int STALL_MAX_MS = 15;
    localparam int STALL_MAX_CYC = STALL_MAX_MS * 1000000 / CLK_PERIOD_NS;
    localparam int HOTJOIN_MS = 1;
    localparam int HOTJOIN_CYC = HOTJOIN_MS * 1000000 / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Activity intervals (cycles)
    // ------------------------------------------------------------
    localparam int AS0_US = 1;
    localparam int AS1_US = 100;
    localparam int AS2_MS = 2;
    localparam int AS3_MS = 50;
    localparam int AS0_CYC = AS0_US * 1000 / CLK_PERIOD_NS;
    localparam int AS1_CYC = AS1_US * 1000 / CLK_PERIOD_NS;
    localparam int AS2_CYC = AS2_MS * 1000000 / CLK_PERIOD_NS;
    localparam int AS3_CYC = AS3_MS * 1000000 / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int CNT_W = 24;
    localparam logic [1:0] AS_RESET = 2'h3;
    localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
    localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
    // Pin low before the stall counter sees it: sync, delay and hold stages
    localparam logic [CNT_W-1:0] STALL_LAG = 24'h000004;

    typedef enum logic [1:0] {
        PULL_NONE = 2'b00,
        PULL_KEEP = 2'b01,
        PULL_OD   = 2'b10
    } pull_type;

    typedef enum logic [1:0] {
        BUS_BUSY  = 2'b00,
        BUS_FREE  = 2'b01,
        BUS_AVAIL = 2'b10,
        BUS_IDLE  = 2'b11
    } cond_type;

    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
        sat_inc = (v == {CNT_W{1'b1}}) ? v : v + CNT_ONE;
    endfunction

endpackage

// [design/line_sense_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface line_sense_if;
    import bus_cond_pkg::*;
    logic scl;
    logic sda;
    logic start;
    logic stop;
    logic scl_fall;
    modport src (output scl, output sda, output start, output stop, output scl_fall);
    modport dst (input scl, input sda, input start, input stop, input scl_fall);
endinterface
`default_nettype wire

// [design/line_sense.sv]
`timescale 1ns/100ps
`default_nettype none
module line_sense
    import bus_cond_pkg::*;
(
    input  wire logic   clk_i,
    input  wire logic   rst_n_i,
    input  wire logic   scl_i,
    input  wire logic   sda_i,
    line_sense_if.src   ls
);
    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic       scl_d;
        logic       sda_d;
        logic       start;
        logic       stop;
        logic       scl_fall;
    } ls_state_type;

    ls_state_type st;
    ls_state_type next_st;

    // ------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.scl_s = {st.scl_s[0], scl_i};
        next_st.sda_s = {st.sda_s[0], sda_i};
        next_st.scl_d = st.scl_s[1];
        next_st.sda_d = st.sda_s[1];
        next_st.start = st.scl_s[1] & st.sda_d & ~st.sda_s[1];
        next_st.stop = st.scl_s[1] & ~st.sda_d & st.sda_s[1];
        next_st.scl_fall = st.scl_d & ~st.scl_s[1];
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '{scl_s: 2'h3, sda_s: 2'h3, scl_d: 1'b1, sda_d: 1'b1, default: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign ls.scl = st.scl_d;
    assign ls.sda = st.sda_d;
    assign ls.start = st.start;
    assign ls.stop = st.stop;
    assign ls.scl_fall = st.scl_fall;
endmodule
`default_nettype wire

// [design/pullup_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
module pullup_ctrl
    import bus_cond_pkg::*;
(
    input  wire logic   clk_i,
    input  wire logic   rst_n_i,
    line_sense_if.dst   ls,
    input  wire logic   od_mode_i,
    input  wire logic   keeper_en_i,
    input  wire logic   power_save_i,
    input  wire logic   bus_inactive_i,
    output pull_type    scl_pull_o,
    output pull_type    sda_pull_o
);
    typedef struct packed {
        pull_type scl_pull;
        pull_type sda_pull;
    } pu_state_type;

    pu_state_type st;
    pu_state_type next_st;
    pull_type     rest;

    // ------------------------------------------------------------
    // Per-line pull selection
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        rest = keeper_en_i ? PULL_KEEP : PULL_NONE;
        next_st.scl_pull = rest;
        next_st.sda_pull = rest;
        if (od_mode_i && !bus_inactive_i) begin
            next_st.scl_pull = PULL_OD;
            next_st.sda_pull = PULL_OD;
            if (power_save_i && keeper_en_i && ls.sda && ls.scl_fall) begin
                next_st.sda_pull = PULL_KEEP;
            end else if (power_save_i && keeper_en_i && ls.sda && !ls.scl &&
                         st.sda_pull == PULL_KEEP) begin
                next_st.sda_pull = PULL_KEEP;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '{scl_pull: PULL_NONE, sda_pull: PULL_NONE};
        end else begin
            st <= next_st;
        end
    end

    assign scl_pull_o = st.scl_pull;
    assign sda_pull_o = st.sda_pull;
endmodule
`default_nettype wire

// [design/bus_cond_tracker.sv]
`timescale 1ns/100ps
`default_nettype none
module bus_cond_tracker
    import bus_cond_pkg::*;
#(
    parameter logic [CNT_W-1:0] STALL_MAX   = CNT_W'(STALL_MAX_CYC),
    parameter logic [CNT_W-1:0] HOTJOIN_MAX = CNT_W'(HOTJOIN_CYC)
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             scl_i,
    input  wire logic             sda_i,
    input  wire logic             mixed_bus_i,
    input  wire logic [CNT_W-1:0] t_cas_i,
    input  wire logic [CNT_W-1:0] t_buf_i,
    input  wire logic [CNT_W-1:0] t_aval_i,
    input  wire logic [CNT_W-1:0] t_idle_i,
    input  wire logic             daa_first_bit_i,
    input  wire logic             stall_req_i,
    input  wire logic             od_mode_i,
    input  wire logic             keeper_en_i,
    input  wire logic             power_save_i,
    input  wire logic             slave_pm_i,
    input  wire logic             entas_i,
    input  wire logic             entas_direct_i,
    input  wire logic [1:0]       entas_level_i,
    output logic                  scl_hold_o,
    output logic                  stall_timeout_o,
    output pull_type              scl_pull_o,
    output pull_type              sda_pull_o,
    output logic                  bus_free_o,
    output logic                  bus_avail_o,
    output logic                  bus_idle_o,
    output logic                  hotjoin_ok_o,
    output cond_type              bus_cond_o,
    output logic [1:0]            act_level_o,
    output logic [CNT_W-1:0]      act_interval_o,
    output logic [CNT_W-1:0]      tcas_max_o,
    output logic                  entas_bcast_o,
    output logic                  entas_direct_o
);
    typedef struct packed {
        logic [CNT_W-1:0] free_cnt;
        logic [CNT_W-1:0] aval_cnt;
        logic [CNT_W-1:0] idle_cnt;
        logic [CNT_W-1:0] quiet_cnt;
        logic [CNT_W-1:0] stall_cnt;
        logic             after_stop;
        logic             free;
        logic             avail;
        logic             idle;
        logic             hotjoin;
        logic             hold;
        logic             timeout;
        logic [1:0]       level;
        logic             bcast;
        logic             direct;
    } top_state_type;

    top_state_type st;
    top_state_type next_st;
    line_sense_if  ls ();
    logic          lines_high;
    logic          kick;
    logic [CNT_W-1:0] free_thr;

    // ------------------------------------------------------------
    // Line sensing and pull control
    // ------------------------------------------------------------
    line_sense u_sense (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .scl_i   (scl_i),
        .sda_i   (sda_i),
        .ls      (ls)
    );

    pullup_ctrl u_pull (
        .clk_i          (clk_i),
        .rst_n_i        (rst_n_i),
        .ls             (ls),
        .od_mode_i      (od_mode_i),
        .keeper_en_i    (keeper_en_i),
        .power_save_i   (power_save_i),
        .bus_inactive_i (st.free),
        .scl_pull_o     (scl_pull_o),
        .sda_pull_o     (sda_pull_o)
    );

    function automatic logic [CNT_W-1:0] level_cycles(input logic [1:0] lv);
        unique case (lv)
            2'h0: level_cycles = CNT_W'(AS0_CYC);
            2'h1: level_cycles = CNT_W'(AS1_CYC);
            2'h2: level_cycles = CNT_W'(AS2_CYC);
            2'h3: level_cycles = CNT_W'(AS3_CYC);
        endcase
    endfunction

    // ------------------------------------------------------------
    // Bus condition timers and activity state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        lines_high = ls.scl & ls.sda;
        kick = ls.start | ~lines_high;
        free_thr = mixed_bus_i ? t_buf_i : t_cas_i;

        if (ls.stop) begin
            next_st.after_stop = 1'b1;
        end else if (ls.start) begin
            next_st.after_stop = 1'b0;
        end

        if (kick || !st.after_stop) begin
            next_st.free_cnt = CNT_ZERO;
            next_st.aval_cnt = CNT_ZERO;
            next_st.idle_cnt = CNT_ZERO;
            next_st.free = 1'b0;
            next_st.avail = 1'b0;
            next_st.idle = 1'b0;
        end else begin
            next_st.free_cnt = sat_inc(st.free_cnt);
            next_st.free = (st.free_cnt >= free_thr);
            if (st.free) begin
                next_st.aval_cnt = sat_inc(st.aval_cnt);
                next_st.avail = (st.aval_cnt >= t_aval_i);
            end
            if (st.avail) begin
                next_st.idle_cnt = sat_inc(st.idle_cnt);
                next_st.idle = (st.idle_cnt >= t_idle_i);
            end
        end

        if (!lines_high || ls.start || ls.scl_fall) begin
            next_st.quiet_cnt = CNT_ZERO;
            next_st.hotjoin = 1'b0;
        end else begin
            next_st.quiet_cnt = sat_inc(st.quiet_cnt);
            next_st.hotjoin = st.idle && (st.quiet_cnt >= HOTJOIN_MAX);
        end

        if (daa_first_bit_i && !st.timeout && !ls.scl) begin
            next_st.hold = stall_req_i;
            next_st.stall_cnt = sat_inc(st.stall_cnt);
            // Low bit time before the stall counts too, not just the hold
            if (st.stall_cnt >= STALL_MAX - STALL_LAG) begin
                next_st.hold = 1'b0;
                next_st.timeout = 1'b1;
            end
        end else begin
            next_st.hold = 1'b0;
            next_st.stall_cnt = CNT_ZERO;
            if (!daa_first_bit_i) begin
                next_st.timeout = 1'b0;
            end
        end

        next_st.bcast = 1'b0;
        next_st.direct = 1'b0;
        if (entas_i && !slave_pm_i) begin
            next_st.level = entas_level_i;
            next_st.bcast = ~entas_direct_i;
            next_st.direct = entas_direct_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '{level: AS_RESET, default: '0};
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign scl_hold_o = st.hold;
    assign stall_timeout_o = st.timeout;
    assign bus_free_o = st.free;
    assign bus_avail_o = st.avail;
    assign bus_idle_o = st.idle;
    assign hotjoin_ok_o = st.hotjoin;
    assign bus_cond_o = st.idle ? BUS_IDLE : st.avail ? BUS_AVAIL :
                        st.free ? BUS_FREE : BUS_BUSY;
    assign act_level_o = st.level;
    assign act_interval_o = level_cycles(st.level);
    assign tcas_max_o = level_cycles(st.level);
    assign entas_bcast_o = st.bcast;
    assign entas_direct_o = st.direct;
endmodule
`default_nettype wire

// [dv/bus_cond_tracker_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module bus_cond_tracker_chk
    import bus_cond_pkg::*;
#(
    parameter logic [CNT_W-1:0] STALL_MAX   = 24'h000032,
    parameter logic [CNT_W-1:0] HOTJOIN_MAX = 24'h000014
) (
    input wire logic             clk_i,
    input wire logic             rst_n_i,
    input wire logic             scl_i,
    input wire logic             keeper_en_i,
    input wire logic             slave_pm_i,
    input wire logic             entas_i,
    input wire logic             entas_direct_i,
    input wire logic [1:0]       entas_level_i,
    input wire logic             scl_hold_o,
    input wire logic             stall_timeout_o,
    input wire pull_type         scl_pull_o,
    input wire pull_type         sda_pull_o,
    input wire logic             bus_free_o,
    input wire logic             bus_avail_o,
    input wire logic             bus_idle_o,
    input wire logic             hotjoin_ok_o,
    input wire logic [1:0]       act_level_o,
    input wire logic [CNT_W-1:0] act_interval_o,
    input wire logic [CNT_W-1:0] tcas_max_o,
    input wire logic             entas_bcast_o,
    input wire logic             entas_direct_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // ----------------
    // Helpers
    // ----------------
    logic [CNT_W-1:0] hold_cnt;

    // Whole SCL low period, stall included
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_cnt <= CNT_ZERO;
        end else begin
            hold_cnt <= scl_i ? CNT_ZERO : hold_cnt + CNT_ONE;
        end
    end

    function automatic logic [CNT_W-1:0] iv(input logic [1:0] l);
        case (l)
            2'h0: return CNT_W'(AS0_CYC);
            2'h1: return CNT_W'(AS1_CYC);
            2'h2: return CNT_W'(AS2_CYC);
            default: return CNT_W'(AS3_CYC);
        endcase
    endfunction

    // ----------------
    // Properties
    // ----------------
    property p_stall_cap; hold_cnt <= STALL_MAX; endproperty
    a_stall_cap: assert property (p_stall_cap) else $error("stall too long");
    property p_stall_end; stall_timeout_o |-> !scl_hold_o; endproperty
    a_stall_end: assert property (p_stall_end) else $error("hold after cap");
    property p_keep_off; !keeper_en_i [*2] |-> sda_pull_o != PULL_KEEP && scl_pull_o != PULL_KEEP;
    endproperty
    a_keep_off: assert property (p_keep_off) else $error("keeper not off");
    property p_avail; bus_avail_o |-> bus_free_o; endproperty
    a_avail: assert property (p_avail) else $error("avail without free");
    property p_idle; bus_idle_o |-> bus_avail_o; endproperty
    a_idle: assert property (p_idle) else $error("idle without avail");
    property p_hj; hotjoin_ok_o |-> bus_idle_o; endproperty
    a_hj: assert property (p_hj) else $error("hot-join not idle");
    property p_iv; act_interval_o == iv(act_level_o) && tcas_max_o == act_interval_o; endproperty
    a_iv: assert property (p_iv) else $error("bad interval");
    property p_cmd; entas_i && !slave_pm_i |=> act_level_o == $past(entas_level_i)
        && entas_direct_o == $past(entas_direct_i) && entas_bcast_o != $past(entas_direct_i);
    endproperty
    a_cmd: assert property (p_cmd) else $error("command not taken");
    property p_pm; entas_i && slave_pm_i |=> $stable(act_level_o) && !entas_bcast_o; endproperty
    a_pm: assert property (p_pm) else $error("command not ignored");
    property p_clr; $fell(scl_i) |-> ##[1:6] !bus_free_o; endproperty
    a_clr: assert property (p_clr) else $error("free not cleared");
endmodule
bind bus_cond_tracker bus_cond_tracker_chk #(.STALL_MAX(STALL_MAX), .HOTJOIN_MAX(HOTJOIN_MAX))
    u_bus_cond_tracker_chk (.*);
`default_nettype wire

// [dv/bus_line_model.sv]
`timescale 1ns/100ps
`default_nettype none
module bus_line_model (
    input  wire logic bus_avail_i,
    output var logic  scl_o,
    output var logic  sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // Start, eight bits, stop; 80 ns bit time
    task automatic frame(input logic [7:0] d);
        #7 sda_o = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            #40 scl_o = 1'b0;
            #20 sda_o = d[i];
            #20 scl_o = 1'b1;
        end
        #40 scl_o = 1'b0;
        #20 sda_o = 1'b0;
        #20 scl_o = 1'b1;
        #20 sda_o = 1'b1;
    endtask
    task automatic start_request(output logic ok);
        ok = 1'b0;
        for (int i = 0; i < 4000 && !ok; i++) begin
            #10 ok = bus_avail_i;
        end
        if (ok) frame(8'h5A);
    endtask
    task automatic hold_scl(input int ns);
        #7 scl_o = 1'b0;
        #(ns) scl_o = 1'b1;
    endtask
endmodule
`default_nettype wire

// [dv/bus_cond_tracker_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module bus_cond_tracker_tb;
    import bus_cond_pkg::*;
    localparam logic [CNT_W-1:0] STALL = 24'h000032;
    localparam logic [CNT_W-1:0] HJ = 24'h000014;
    localparam logic [CNT_W-1:0] IV [4] = '{CNT_W'(AS0_CYC), CNT_W'(AS1_CYC),
                                             CNT_W'(AS2_CYC), CNT_W'(AS3_CYC)};
    logic             clk_i = 1'b0;
    logic             rst_n_i = 1'b0;
    logic             mixed_bus_i, daa_first_bit_i, stall_req_i, od_mode_i, keeper_en_i;
    logic             power_save_i, slave_pm_i, entas_i, entas_direct_i;
    logic [1:0]       entas_level_i, act_level_o;
    logic [CNT_W-1:0] t_cas_i, t_buf_i, t_aval_i, t_idle_i, act_interval_o, tcas_max_o;
    logic             scl_hold_o, stall_timeout_o, bus_free_o, bus_avail_o, bus_idle_o;
    logic             hotjoin_ok_o, entas_bcast_o, entas_direct_o;
    pull_type         scl_pull_o, sda_pull_o;
    cond_type         bus_cond_o;
    wire logic        scl_m, scl_i, sda_i;
    int               checked = 0, miscompares = 0, seed = 32'h36C7A15C;
    logic [2:0]       notes [$];

    always #5 clk_i = ~clk_i;
    // Wired-AND of the far side and the stall
    assign scl_i = scl_m & ~scl_hold_o;

    bus_cond_tracker #(.STALL_MAX(STALL), .HOTJOIN_MAX(HJ)) u_bus_cond_tracker (.*);
    bus_line_model u_bus_line_model (.bus_avail_i(bus_avail_o), .scl_o(scl_m), .sda_o(sda_i));

    // ----------------
    // Checking
    // ----------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    function automatic logic flag(input int k);
        return k == 0 ? bus_free_o : k == 1 ? bus_avail_o : k == 2 ? bus_idle_o :
               k == 3 ? hotjoin_ok_o : stall_timeout_o;
    endfunction
    task automatic wait_flag(input int k, output int n);
        n = 0;
        while (flag(k) !== 1'b1) begin
            @(posedge clk_i);
            #1;
            n++;
            if (n > 5000) begin
                miscompares++;
                report_and_stop();
            end
        end
    endtask
    always @(posedge clk_i) begin
        logic [2:0] e;
        #1;
        if (entas_bcast_o === 1'b1 || entas_direct_o === 1'b1) begin
            e = notes.size() > 0 ? notes.pop_front() : 3'h7;
            check("entas", {entas_direct_o, act_level_o}, e);
            check("interval", act_interval_o, IV[e[1:0]]);
            check("tcas", tcas_max_o, IV[e[1:0]]);
        end
    end

    // ----------------
    // Stimulus
    // ----------------
    task automatic issue(input logic dir, input logic [1:0] lvl);
        entas_i <= 1'b1;
        entas_direct_i <= dir;
        entas_level_i <= lvl;
        if (!slave_pm_i) notes.push_back({dir, lvl});
        @(posedge clk_i);
    endtask
    task automatic frame_free(input string what, input int thr);
        int n;
        fork
            u_bus_line_model.frame(8'($random(seed)));
            begin
                repeat (20) @(posedge clk_i);
                #1;
                check("busy_free", bus_free_o, 0);
                check("busy_pull", scl_pull_o, PULL_OD);
            end
        join
        wait_flag(0, n);
        check(what, n >= thr + 2 && n <= thr + 7, 1);
    endtask

    initial begin
        int n;
        logic ok;
        {mixed_bus_i, daa_first_bit_i, stall_req_i, power_save_i, slave_pm_i} <= '0;
        // Open-drain mode with keeper on
        {entas_i, entas_direct_i, od_mode_i, keeper_en_i, entas_level_i} <= 6'h0C;
        {t_cas_i, t_buf_i} <= {24'h00001E, 24'h00003C};
        {t_aval_i, t_idle_i} <= {24'h000028, 24'h000050};
        repeat (6) @(posedge clk_i);
        check("rst_level", act_level_o, 2'h3);
        check("rst_pull", sda_pull_o, PULL_NONE);
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (200) @(posedge clk_i);
        check("no_stop_free", bus_free_o, 0);
        $display("test reset done");
        for (int i = 0; i < 12; i++) issue(i[2], i < 8 ? i[1:0] : 2'($random(seed)));
        slave_pm_i <= 1'b1;
        entas_i <= 1'b0;
        @(posedge clk_i);
        issue(1'b1, 2'h0);
        entas_i <= 1'b0;
        slave_pm_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        check("notes_left", notes.size(), 0);
        $display("test activity done");
        frame_free("free_pure", t_cas_i);
        mixed_bus_i <= 1'b1;
        power_save_i <= 1'b1;
        frame_free("free_mixed", t_buf_i);
        // Pulls follow the free flag one edge later
        @(posedge clk_i);
        #1;
        check("free_pull", sda_pull_o, PULL_KEEP);
        check("free_scl_pull", scl_pull_o, PULL_KEEP);
        wait_flag(1, n);
        check("avail", n >= t_aval_i - 2 && n <= t_aval_i + 3, 1);
        wait_flag(2, n);
        check("idle", n >= t_idle_i - 2 && n <= t_idle_i + 3, 1);
        check("cond", bus_cond_o, BUS_IDLE);
        wait_flag(3, n);
        // Quiet window long past, so idle alone gates it
        check("hotjoin", n >= 1 && n <= 2, 1);
        keeper_en_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        check("keeper_off", sda_pull_o, PULL_NONE);
        keeper_en_i <= 1'b1;
        u_bus_line_model.start_request(ok);
        check("request", ok, 1);
        $display("test conditions done");
        @(posedge clk_i);
        daa_first_bit_i <= 1'b1;
        stall_req_i <= 1'b1;
        fork
            u_bus_line_model.hold_scl(200);
            begin
                repeat (10) @(posedge clk_i);
                #1;
                check("hold", scl_hold_o, 1);
                check("keep_sda", sda_pull_o, PULL_KEEP);
                wait_flag(4, n);
                check("stall_len", n >= STALL - 10 && n <= STALL + 2, 1);
                check("released", scl_i, 1);
            end
        join
        $display("test stall done");
        report_and_stop();
    end
endmodule
`default_nettype wire
